// *** pkg/arsp_pkg.sv ***
// Purpose: Shared constants for the reset / standby / powerdown control block
// Assumes: Byte-wide register port, offsets are register indices on page 0
// Notes: Reserved bits read as zero
package arsp_pkg;
    localparam logic [7:0] ARSP_ADDR_RESET_CTRL = 8'h01;
    localparam logic [7:0] ARSP_ADDR_POWER_CTRL = 8'h02;
    localparam int ARSP_BIT_MODULE_RESET = 4;
    localparam int ARSP_BIT_REGISTER_RESET = 0;
    localparam int ARSP_BIT_PROC_RESET = 7;
    localparam int ARSP_BIT_STANDBY_REQ = 4;
    localparam int ARSP_BIT_POWERDOWN_REQ = 0;
    localparam logic ARSP_RST_PROC_RESET = 1'b1;
    localparam logic ARSP_RST_STANDBY_REQ = 1'b0;
    localparam logic ARSP_RST_POWERDOWN_REQ = 1'b0;
    // Length of the reset pulse sent to the cleared modules
    localparam int ARSP_PULSE_CYCLES = 4;
    localparam logic [2:0] ARSP_PULSE_LOAD = 3'(ARSP_PULSE_CYCLES);

    typedef enum logic [1:0]
    {
        ARSP_MODE_RUN = 2'b00,
        ARSP_MODE_STANDBY = 2'b01,
        ARSP_MODE_POWERDOWN = 2'b10
    } arsp_mode_t;
endpackage

// *** pkg/arsp_pulse_if.sv ***
// Purpose: Carrier between the register file and the reset pulse stretcher
// Assumes: Single clock
// Notes: start is a one-cycle request, busy is high while the pulse runs
`timescale 1ns/1ps
interface arsp_pulse_if;
    logic start;
    logic busy;
    modport ctrl (output start, input busy);
    modport gen (input start, output busy);
endinterface

// *** design/arsp_pulse_gen.sv ***
// Purpose: Stretches a one-cycle start into a fixed-length reset pulse
// Assumes: start is synchronous to clk_sys
// Notes: A start during a running pulse restarts the count
`timescale 1ns/1ps
module arsp_pulse_gen
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control carrier
    arsp_pulse_if.gen pulse
);
    import arsp_pkg::*;

    logic [2:0] count_reg;
    logic [2:0] count_next;

    assign count_next = pulse.start ? ARSP_PULSE_LOAD :
                        (count_reg != 3'h0) ? count_reg - 3'h1 : 3'h0;
    assign pulse.busy = (count_reg != 3'h0);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            count_reg <= 3'h0;
        else
            count_reg <= count_next;
    end
endmodule

// *** design/arsp_ctrl.sv ***
// Purpose: Reset, standby and powerdown control for an audio amplifier core
// Assumes: Byte register port with one-cycle write and read strobes, clk_sys 40 MHz
// Notes: Clock error input comes from another domain and is synchronised here
// Behaviour
// - Module reset clears filter, converter, processor, coefficients
// - Module reset self-clears; accepted only in standby or powerdown
// - Register reset restores modes, execution back to ROM
// - Processor reset starts one; clearing starts processing
// - Standby request bit forces system standby
// - Clock error also forces standby
// - Standby keeps charge pump and digital supply
// - Powerdown request also stops charge pump
// - Powerdown wins over standby
`timescale 1ns/1ps
module arsp_ctrl
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Status from the clock monitor
    input wire logic clock_error,
    // Controls to the amplifier core
    output logic filter_converter_reset,
    output logic processor_reset,
    output logic coeff_clear,
    output logic mode_regs_reset,
    output logic exec_from_rom,
    output logic subsystems_power_en,
    output logic charge_pump_en,
    output logic digital_supply_en,
    output arsp_pkg::arsp_mode_t power_mode
);
    import arsp_pkg::*;

    arsp_pulse_if mod_pulse ();
    arsp_pulse_if reg_pulse ();

    arsp_pulse_gen u_mod_pulse
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pulse(mod_pulse.gen)
    );

    arsp_pulse_gen u_reg_pulse
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pulse(reg_pulse.gen)
    );

    logic clk_err_meta_reg;
    logic clk_err_sync_reg;
    logic proc_reset_reg;
    logic standby_req_reg;
    logic powerdown_req_reg;
    logic exec_rom_reg;
    arsp_mode_t mode_reg;
    arsp_mode_t mode_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] reset_ctrl_view;
    logic [7:0] power_ctrl_view;
    logic wr_reset_ctrl;
    logic wr_power_ctrl;
    logic in_standby;
    logic mod_start;
    logic reg_start;
    logic hit_reset_ctrl;
    logic hit_power_ctrl;
    logic standby_cause;

    // True when the byte address selects the given control register
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
        return (addr == target);
    endfunction

    // Powerdown outranks every standby cause; odd inputs fall back to standby
    function automatic arsp_mode_t pick_mode(input logic pd_req, input logic sb_cause);
        arsp_mode_t mode;
        mode = ARSP_MODE_STANDBY;
        case ({pd_req, sb_cause})
            2'b00: mode = ARSP_MODE_RUN;
            2'b01: mode = ARSP_MODE_STANDBY;
            2'b10: mode = ARSP_MODE_POWERDOWN;
            2'b11: mode = ARSP_MODE_POWERDOWN;
            default: mode = ARSP_MODE_STANDBY;
        endcase
        return mode;
    endfunction

    // Self-clearing bits read back as one only while their pulse runs
    function automatic logic [7:0] reset_ctrl_image(input logic mod_busy, input logic reg_busy);
        logic [7:0] image;
        image = 8'h00;
        image[ARSP_BIT_MODULE_RESET] = mod_busy;
        image[ARSP_BIT_REGISTER_RESET] = reg_busy;
        return image;
    endfunction

    // Reserved bits read as zero
    function automatic logic [7:0] power_ctrl_image
    (
        input logic proc_reset,
        input logic standby_req,
        input logic powerdown_req
    );
        logic [7:0] image;
        image = 8'h00;
        image[ARSP_BIT_PROC_RESET] = proc_reset;
        image[ARSP_BIT_STANDBY_REQ] = standby_req;
        image[ARSP_BIT_POWERDOWN_REQ] = powerdown_req;
        return image;
    endfunction

    assign hit_reset_ctrl = addr_is(reg_addr, ARSP_ADDR_RESET_CTRL);
    assign hit_power_ctrl = addr_is(reg_addr, ARSP_ADDR_POWER_CTRL);
    assign wr_reset_ctrl = reg_wr && hit_reset_ctrl;
    assign wr_power_ctrl = reg_wr && hit_power_ctrl;
    // Standby or deeper counts as not running
    assign in_standby = (mode_reg != ARSP_MODE_RUN);
    // Module reset ignored unless already stopped
    assign mod_start = wr_reset_ctrl && reg_wdata[ARSP_BIT_MODULE_RESET] && in_standby;
    // Register reset trusts software to be in standby
    assign reg_start = wr_reset_ctrl && reg_wdata[ARSP_BIT_REGISTER_RESET];
    assign mod_pulse.start = mod_start;
    assign reg_pulse.start = reg_start;

    // Powerdown first, then any standby cause
    assign standby_cause = standby_req_reg || clk_err_sync_reg;
    assign mode_next = pick_mode(powerdown_req_reg, standby_cause);

    assign reset_ctrl_view = reset_ctrl_image(mod_pulse.busy, reg_pulse.busy);
    assign power_ctrl_view = power_ctrl_image(proc_reset_reg, standby_req_reg,
                                              powerdown_req_reg);
    assign rdata_next = !reg_rd ? rdata_reg :
                        hit_reset_ctrl ? reset_ctrl_view :
                        hit_power_ctrl ? power_ctrl_view : 8'h00;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            clk_err_meta_reg <= 1'b0;
            clk_err_sync_reg <= 1'b0;
        end
        else
        begin
            clk_err_meta_reg <= clock_error;
            clk_err_sync_reg <= clk_err_meta_reg;
        end
    end

    // Register reset returns mode bits to their reset values
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || reg_pulse.busy)
        begin
            proc_reset_reg <= ARSP_RST_PROC_RESET;
            standby_req_reg <= ARSP_RST_STANDBY_REQ;
            powerdown_req_reg <= ARSP_RST_POWERDOWN_REQ;
        end
        else if (wr_power_ctrl)
        begin
            proc_reset_reg <= reg_wdata[ARSP_BIT_PROC_RESET];
            standby_req_reg <= reg_wdata[ARSP_BIT_STANDBY_REQ];
            powerdown_req_reg <= reg_wdata[ARSP_BIT_POWERDOWN_REQ];
        end
    end

    // Execution source: ROM after reset or register reset, RAM stays intact
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || reg_pulse.busy)
            exec_rom_reg <= 1'b1;
        else
            exec_rom_reg <= exec_rom_reg;
    end

    // Mode and read data
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            mode_reg <= ARSP_MODE_STANDBY;
            rdata_reg <= 8'h00;
        end
        else
        begin
            mode_reg <= mode_next;
            rdata_reg <= rdata_next;
        end
    end

    // Reset lines to the core follow the pulses one cycle late
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            filter_converter_reset <= 1'b1;
            processor_reset <= 1'b1;
            coeff_clear <= 1'b0;
            mode_regs_reset <= 1'b0;
            exec_from_rom <= 1'b1;
        end
        else
        begin
            filter_converter_reset <= mod_pulse.busy;
            processor_reset <= proc_reset_reg || mod_pulse.busy;
            coeff_clear <= mod_pulse.busy;
            mode_regs_reset <= reg_pulse.busy;
            exec_from_rom <= exec_rom_reg;
        end
    end

    // Supply enables move together with power_mode, so they never disagree
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            subsystems_power_en <= 1'b0;
            charge_pump_en <= 1'b1;
            digital_supply_en <= 1'b1;
            power_mode <= ARSP_MODE_STANDBY;
        end
        else
        begin
            subsystems_power_en <= (mode_reg == ARSP_MODE_RUN);
            charge_pump_en <= (mode_reg != ARSP_MODE_POWERDOWN);
            digital_supply_en <= 1'b1;
            power_mode <= mode_reg;
        end
    end

    assign reg_rdata = rdata_reg;
endmodule

// *** dv/arsp_ctrl_monitor.sv ***
// Purpose: Port checks for arsp_ctrl
// Assumes: One clock, sync reset
// Notes: Pulses last four cycles
`timescale 1ns/1ps
module arsp_ctrl_monitor
(
    // Clock and reset
    input logic clk_sys,
    input logic rst_n,
    // Core controls
    input logic filter_converter_reset,
    input logic processor_reset,
    input logic coeff_clear,
    input logic mode_regs_reset,
    input logic subsystems_power_en,
    input logic charge_pump_en,
    input logic digital_supply_en,
    input arsp_pkg::arsp_mode_t power_mode
);
    import arsp_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_pulse(s); s[*4] ##1 !s; endsequence
    property p_pd; power_mode == ARSP_MODE_POWERDOWN |-> !charge_pump_en; endproperty
    a_pd: assert property (p_pd) else $error("pump on");
    property p_cp; !charge_pump_en |-> power_mode == ARSP_MODE_POWERDOWN; endproperty
    a_cp: assert property (p_cp) else $error("pump off");
    property p_sb; power_mode == ARSP_MODE_STANDBY |-> !subsystems_power_en; endproperty
    a_sb: assert property (p_sb) else $error("standby on");
    property p_run; power_mode == ARSP_MODE_RUN |-> subsystems_power_en; endproperty
    a_run: assert property (p_run) else $error("run off");
    property p_dig; digital_supply_en; endproperty
    a_dig: assert property (p_dig) else $error("supply off");
    property p_mod; coeff_clear |-> filter_converter_reset && processor_reset; endproperty
    a_mod: assert property (p_mod) else $error("partial reset");
    property p_mlen; $rose(coeff_clear) |-> s_pulse(coeff_clear); endproperty
    a_mlen: assert property (p_mlen) else $error("module pulse");
    property p_rlen; $rose(mode_regs_reset) |-> s_pulse(mode_regs_reset); endproperty
    a_rlen: assert property (p_rlen) else $error("register pulse");
endmodule
bind arsp_ctrl arsp_ctrl_monitor i_arsp_ctrl_monitor (.*);

// *** dv/arsp_ctrl_tb.sv ***
// Purpose: Self-checking bench for arsp_ctrl
// Assumes: clk_sys 40 MHz
// Notes: Rows walk the power modes
`timescale 1ns/1ps
module arsp_ctrl_tb;
    import arsp_pkg::*;
    logic clk_sys, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clock_error = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic filter_converter_reset, processor_reset, coeff_clear, mode_regs_reset;
    logic exec_from_rom, subsystems_power_en, charge_pump_en, digital_supply_en;
    arsp_mode_t power_mode;
    int fail_count = 0, n_compared = 0;
    wire [4:0] st = {power_mode, charge_pump_en, subsystems_power_en, processor_reset};
    localparam logic [7:0] ra = ARSP_ADDR_RESET_CTRL, pa = ARSP_ADDR_POWER_CTRL, na = 8'h05;
    logic [15:0] rows [5] = '{16'h0006, 16'h100c, 16'h0110, 16'h1110, 16'h900d};
    arsp_ctrl i_arsp_ctrl (.*);
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        fail_count += int'(s !== e);
        if (s !== e) $display("MISMATCH %0t got %h expected %h", $time, s, e);
    endtask
    task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d, input int n);
        @(posedge clk_sys) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {~r, r, a, d};
        @(posedge clk_sys) {reg_wr, reg_rd} <= 2'b00;
        repeat (n) @(posedge clk_sys);
        #1;
        if (r) chk(reg_rdata, d);
    endtask
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        #50us;
        fail_count++;
        stop_test;
    end
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        acc(1'b1, ra, 8'h00, 0);
        acc(1'b1, pa, 8'h80, 0);
        acc(1'b1, na, 8'h00, 0);
        foreach (rows[i])
        begin
            acc(1'b0, pa, rows[i][15:8], 4);
            chk({3'h0, st}, rows[i][7:0]);
        end
        acc(1'b0, pa, 8'h00, 3);
        acc(1'b0, ra, 8'h10, 2);
        chk({7'h0, coeff_clear}, 8'h00);
        acc(1'b0, pa, 8'h10, 3);
        acc(1'b0, ra, 8'h10, 2);
        chk({5'h0, coeff_clear, filter_converter_reset, processor_reset}, 8'h07);
        acc(1'b0, na, 8'h00, 2);
        acc(1'b1, ra, 8'h00, 0);
        acc(1'b0, ra, 8'h01, 2);
        chk({6'h0, mode_regs_reset, exec_from_rom}, 8'h03);
        acc(1'b0, na, 8'h00, 3);
        acc(1'b1, pa, 8'h80, 0);
        @(posedge clk_sys) clock_error <= 1'b1;
        acc(1'b0, na, 8'h00, 4);
        chk({3'h0, st}, 8'h0d);
        // Mid-run reset: reset values, then the first two edges after release
        @(posedge clk_sys) {rst_n, clock_error} <= 2'b00;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({3'h0, st}, 8'h0d);
        chk({6'h0, filter_converter_reset, digital_supply_en}, 8'h03);
        @(posedge clk_sys) rst_n <= 1'b1;
        @(posedge clk_sys) #1;
        chk({3'h0, st}, 8'h0d);
        chk({7'h0, filter_converter_reset}, 8'h00);
        @(posedge clk_sys) #1;
        chk({3'h0, st}, 8'h07);
        stop_test;
    end
endmodule
